// file: rtl/lcms_sync2.v
`timescale 1ns/1ps
module lcms_sync2 #(
   parameter W       = 1,
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire         clock_i,
   input  wire         reset_i,
   // data
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clock_i) begin
      if (reset_i) begin
         meta_q <= {W{RST_VAL}};
         sync_q <= {W{RST_VAL}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // lcms_sync2

// file: rtl/lcms_top.v
`timescale 1ns/1ps
`include "lcms_defines.vh"
module lcms_top (
   // clock and reset
   input  wire        clock_i,
   input  wire        reset_i,
   // control mode strap
   input  wire [1:0]  mode_select_i,
   // hardware configuration pins
   input  wire        rx_clock_edge_select_i,
   input  wire        rail_coding_select_hi_i,
   input  wire        rail_coding_select_lo_i,
   input  wire        ch1_loopback_select_hi_i,
   input  wire        ch1_loopback_select_lo_i,
   // receive rails
   input  wire        recovered_rx_clock_i,
   input  wire        rail_pos_in_i,
   input  wire        rail_neg_in_i,
   output reg         rx_rail_positive_o,
   output reg         rx_rail_negative_o,
   // parallel microcontroller port
   input  wire        cs_n_i,
   input  wire [5:0]  addr_i,
   input  wire        data_or_read_strobe_n_i,
   input  wire        dir_or_write_strobe_n_i,
   input  wire [7:0]  data_i,
   output reg  [7:0]  data_o,
   output reg         data_oe_o,
   // interrupt sources and output
   input  wire [15:0] irq_event_i,
   output reg         int_o,
   output reg         int_oe_o,
   // decoded configuration
   output reg  [1:0]  control_mode_o,
   output reg         dual_rail_o,
   output reg         line_code_ami_o,
   output reg         clock_data_recovery_o,
   output reg         loop_analog_o,
   output reg         loop_digital_o,
   output reg         loop_remote_o,
   output reg         loop_inband_o
);
   wire [1:0]  mode_s;
   wire        edge_s;
   wire [1:0]  coding_s;
   wire [1:0]  loop_s;
   wire        rclk_s;
   wire [5:0]  addr_s;
   wire [7:0]  data_s;
   wire        cs_n_s;
   wire        data_or_read_strobe_n_s;
   wire        rw_wr_n_s;

   // strap pins cross into the clock domain
   lcms_sync2 #(
      .W       (2),
      .RST_VAL (1'b0)
   ) u_sync_strap (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i (mode_select_i),
      .sync_o  (mode_s)
   );

   // hardware configuration pins
   lcms_sync2 #(
      .W       (5),
      .RST_VAL (1'b0)
   ) u_sync_hw (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i ({rx_clock_edge_select_i,
                 rail_coding_select_hi_i, rail_coding_select_lo_i,
                 ch1_loopback_select_hi_i, ch1_loopback_select_lo_i}),
      .sync_o  ({edge_s, coding_s, loop_s})
   );

   // receive clock has its own pair; reset low matches the idle pin,
   // so no false edge follows reset
   lcms_sync2 #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_sync_rclk (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i (recovered_rx_clock_i),
      .sync_o  (rclk_s)
   );

   // address and data are copied bit by bit; safe only because they
   // stand still for three clocks before the strobes move
   lcms_sync2 #(
      .W       (14),
      .RST_VAL (1'b0)
   ) u_sync_bus (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i ({addr_i, data_i}),
      .sync_o  ({addr_s, data_s})
   );

   // active low controls idle high through reset
   lcms_sync2 #(
      .W       (3),
      .RST_VAL (1'b1)
   ) u_sync_ctl (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i ({cs_n_i, data_or_read_strobe_n_i, dir_or_write_strobe_n_i}),
      .sync_o  ({cs_n_s, data_or_read_strobe_n_s, rw_wr_n_s})
   );

   // strap capture once the synchroniser has filled
   reg  [1:0]  settle_q;
   reg         strap_done_q;
   reg  [1:0]  mode_q;

   always @(posedge clock_i) begin
      if (reset_i) begin
         settle_q     <= 2'd0;
         strap_done_q <= 1'b0;
         mode_q       <= `LCMS_MODE_HW;
      end else if (!strap_done_q) begin
         if (settle_q == `LCMS_STRAP_SETTLE - 2'd1) begin
            strap_done_q <= 1'b1;
            mode_q       <= mode_s;
         end else begin
            settle_q <= settle_q + 2'd1;
         end
      end
   end

   wire hw_mode  = (mode_q == `LCMS_MODE_HW);
   wire par_ds   = (mode_q == `LCMS_MODE_PAR_DS);
   wire par_rw   = (mode_q == `LCMS_MODE_PAR_RW);
   // serial port shifting lives elsewhere; here serial mode just
   // keeps the parallel strobes from being decoded
   wire par_mode = strap_done_q & (par_ds | par_rw);

   // parallel access decode
   wire cs_act = par_mode & ~cs_n_s;
   wire rd_act = cs_act & (par_ds ? (~data_or_read_strobe_n_s & rw_wr_n_s)
                                  : ~data_or_read_strobe_n_s);
   wire wr_act = cs_act & (par_ds ? (~data_or_read_strobe_n_s & ~rw_wr_n_s)
                                  : ~rw_wr_n_s);
   reg  wr_prev_q;
   wire wr_take = wr_act & ~wr_prev_q;

   reg  [7:0]  cfg_q;
   reg  [7:0]  mask_lo_q;
   reg  [7:0]  mask_hi_q;
   reg  [7:0]  int_ctrl_q;
   reg  [15:0] status_q;
   reg  [15:0] status_clr;
   reg  [7:0]  rd_data;

   always @* begin
      status_clr = 16'h0000;
      if (wr_take && addr_s == `LCMS_OFS_STAT_LO) begin
         status_clr[7:0] = data_s;
      end
      if (wr_take && addr_s == `LCMS_OFS_STAT_HI) begin
         status_clr[15:8] = data_s;
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         wr_prev_q  <= 1'b0;
         cfg_q      <= `LCMS_RST_CONFIG;
         mask_lo_q  <= `LCMS_RST_MASK;
         mask_hi_q  <= `LCMS_RST_MASK;
         int_ctrl_q <= `LCMS_RST_INT_CTRL;
         status_q   <= 16'h0000;
      end else begin
         wr_prev_q <= wr_act;
         if (wr_take) begin
            case (addr_s)
               `LCMS_OFS_CONFIG:   cfg_q      <= data_s;
               `LCMS_OFS_MASK_LO:  mask_lo_q  <= data_s;
               `LCMS_OFS_MASK_HI:  mask_hi_q  <= data_s;
               `LCMS_OFS_INT_CTRL: int_ctrl_q <= data_s;
               default: ;
            endcase
         end
         // a new event wins over a clear in the same cycle
         status_q <= (status_q & ~status_clr) | irq_event_i;
      end
   end

   always @* begin
      case (addr_s)
         `LCMS_OFS_CONFIG:    rd_data = cfg_q;
         `LCMS_OFS_MODE_STAT: rd_data = {6'h00, mode_q};
         `LCMS_OFS_MASK_LO:   rd_data = mask_lo_q;
         `LCMS_OFS_MASK_HI:   rd_data = mask_hi_q;
         `LCMS_OFS_STAT_LO:   rd_data = status_q[7:0];
         `LCMS_OFS_STAT_HI:   rd_data = status_q[15:8];
         `LCMS_OFS_INT_CTRL:  rd_data = int_ctrl_q;
         default:             rd_data = 8'h00;
      endcase
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         data_o    <= 8'h00;
         data_oe_o <= 1'b0;
      end else begin
         data_oe_o <= rd_act;
         data_o    <= rd_act ? rd_data : 8'h00;
      end
   end

   // interrupt merge and driver
   wire [15:0] mask_all = {mask_hi_q, mask_lo_q};
   wire        irq_any  = |(status_q & ~mask_all);
   wire        irq_req  = irq_any & ~int_ctrl_q[`LCMS_ICTL_GMASK];

   reg         int_d;
   reg         int_oe_d;

   always @* begin
      int_d    = 1'b0;
      int_oe_d = 1'b1;
      if (int_ctrl_q[`LCMS_ICTL_OPEN_DRN]) begin
         // open drain only pulls low; the board pull-up gives the idle level
         int_oe_d = irq_req;
      end else begin
         int_d = int_ctrl_q[`LCMS_ICTL_ACT_HIGH] ? irq_req : ~irq_req;
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         int_o    <= 1'b0;
         int_oe_o <= 1'b0;
      end else begin
         int_o    <= int_d;
         int_oe_o <= int_oe_d;
      end
   end

   // effective configuration: pins in hardware mode, register otherwise
   wire       eff_edge   = hw_mode ? edge_s
                                   : cfg_q[`LCMS_CFG_EDGE];
   wire [1:0] eff_coding = hw_mode ? coding_s
                                   : cfg_q[`LCMS_CFG_CODING_LO +: 2];
   wire [1:0] eff_loop   = hw_mode ? loop_s
                                   : cfg_q[`LCMS_CFG_LOOP_LO +: 2];

   always @(posedge clock_i) begin
      if (reset_i) begin
         control_mode_o        <= `LCMS_MODE_HW;
         dual_rail_o           <= 1'b0;
         line_code_ami_o       <= 1'b0;
         clock_data_recovery_o <= 1'b1;
         loop_analog_o         <= 1'b0;
         loop_digital_o        <= 1'b0;
         loop_remote_o         <= 1'b0;
         loop_inband_o         <= 1'b0;
      end else begin
         control_mode_o <= mode_q;
         case (eff_coding)
            `LCMS_CODING_SR_LINE: begin
               dual_rail_o           <= 1'b0;
               line_code_ami_o       <= 1'b0;
               clock_data_recovery_o <= 1'b1;
            end
            `LCMS_CODING_SR_AMI: begin
               dual_rail_o           <= 1'b0;
               line_code_ami_o       <= 1'b1;
               clock_data_recovery_o <= 1'b1;
            end
            `LCMS_CODING_DR_CDR: begin
               dual_rail_o           <= 1'b1;
               line_code_ami_o       <= 1'b0;
               clock_data_recovery_o <= 1'b1;
            end
            default: begin
               dual_rail_o           <= 1'b1;
               line_code_ami_o       <= 1'b0;
               clock_data_recovery_o <= 1'b0;
            end
         endcase
         loop_analog_o  <= (eff_loop == `LCMS_LOOP_ANALOG);
         loop_digital_o <= (eff_loop == `LCMS_LOOP_DIGITAL);
         loop_remote_o  <= (eff_loop == `LCMS_LOOP_REMOTE);
         // pins have no way to request in-band loopback
         loop_inband_o  <= ~hw_mode & cfg_q[`LCMS_CFG_INBAND];
      end
   end

   // receive rails follow the chosen edge of the recovered clock;
   // edges are seen two cycles late, so the clock must be well below 20 MHz
   reg  rclk_prev_q;
   wire rclk_rise = rclk_s & ~rclk_prev_q;
   wire rclk_fall = ~rclk_s & rclk_prev_q;

   always @(posedge clock_i) begin
      if (reset_i) begin
         rclk_prev_q        <= 1'b0;
         rx_rail_positive_o <= 1'b0;
         rx_rail_negative_o <= 1'b0;
      end else begin
         rclk_prev_q <= rclk_s;
         if (eff_edge ? rclk_fall : rclk_rise) begin
            rx_rail_positive_o <= rail_pos_in_i;
            rx_rail_negative_o <= rail_neg_in_i;
         end
      end
   end
endmodule // lcms_top

// file: shared/lcms_defines.vh
// Overview of operation
// - strap 00 hardware pins, 01 serial, 10 strobe-style, 11 read/write-strobe parallel
// - parallel port: chip select, 6-bit address, 8-bit data, two strobes, interrupt
// - hardware mode: rails update on rising clock edge if select low, falling if high
// - hardware coding 00 single rail line code, 11 slicer dual rail without recovery
// - microcontroller accesses only honoured while chip select is low
// - hardware loopback 00 none, 11 remote, other codes analog and digital
// - loopback code 01 analog, code 10 digital
// - in-band loopback only under software control, never in hardware mode
// - all interrupt sources merge into one interrupt output
// - global mask bit at one blocks the interrupt output entirely
// - each source maskable through mask registers at 13h and 14h
// - pending sources in status registers 18h and 19h, control at 21h
// - interrupt driver configurable: push-pull high or low, or open drain
`ifndef LCMS_DEFINES_VH
`define LCMS_DEFINES_VH

`define LCMS_MODE_HW        2'b00
`define LCMS_MODE_SERIAL    2'b01
`define LCMS_MODE_PAR_DS    2'b10
`define LCMS_MODE_PAR_RW    2'b11

`define LCMS_CODING_SR_LINE 2'b00
`define LCMS_CODING_SR_AMI  2'b01
`define LCMS_CODING_DR_CDR  2'b10
`define LCMS_CODING_SLICER  2'b11

`define LCMS_LOOP_NONE      2'b00
`define LCMS_LOOP_ANALOG    2'b01
`define LCMS_LOOP_DIGITAL   2'b10
`define LCMS_LOOP_REMOTE    2'b11

`define LCMS_OFS_CONFIG     6'h01
`define LCMS_OFS_MODE_STAT  6'h02
`define LCMS_OFS_MASK_LO    6'h13
`define LCMS_OFS_MASK_HI    6'h14
`define LCMS_OFS_STAT_LO    6'h18
`define LCMS_OFS_STAT_HI    6'h19
`define LCMS_OFS_INT_CTRL   6'h21

`define LCMS_CFG_EDGE       0
`define LCMS_CFG_CODING_LO  1
`define LCMS_CFG_LOOP_LO    3
`define LCMS_CFG_INBAND     5

`define LCMS_ICTL_GMASK     0
`define LCMS_ICTL_ACT_HIGH  1
`define LCMS_ICTL_OPEN_DRN  2

`define LCMS_RST_CONFIG     8'h00
`define LCMS_RST_MASK       8'hFF
`define LCMS_RST_INT_CTRL   8'h01

`define LCMS_STRAP_SETTLE   2'd3

`endif

// file: tb/lcms_mcu_model.sv
`timescale 1ns/1ps
module lcms_mcu_model (
   // clock and port style
   input  wire       clock_i,
   input  wire       par_ds_i,
   // answer from the device
   input  wire [7:0] rdata_i,
   input  wire       rdata_oe_i,
   // bus pins
   output reg        cs_n_o,
   output reg  [5:0] addr_o,
   output reg        strb_n_o,
   output reg        dir_n_o,
   output reg  [7:0] data_o
);
   initial begin
      cs_n_o = 1'b1;
      addr_o = 6'h00;
      strb_n_o = 1'b1;
      dir_n_o = 1'b1;
      data_o = 8'h5a;
   end
   task tick(input integer n);
      repeat (n) @(posedge clock_i);
   endtask
   // address and data lead the strobe by 3 clocks for the device's synchronisers
   task wr(input [5:0] a, input [7:0] d, input sel);
      begin
         cs_n_o <= !sel;
         addr_o <= a;
         data_o <= d;
         tick(3);
         strb_n_o <= !par_ds_i;
         dir_n_o <= 1'b0;
         tick(4);
         strb_n_o <= 1'b1;
         dir_n_o <= 1'b1;
         tick(4);
         cs_n_o <= 1'b1;
         data_o <= ~d;
         tick(1);
      end
   endtask
   task rd(input [5:0] a, output [7:0] d);
      integer i;
      begin
         cs_n_o <= 1'b0;
         addr_o <= a;
         tick(3);
         strb_n_o <= 1'b0;
         for (i = 0; i < 8 && rdata_oe_i !== 1'b1; i++) @(posedge clock_i);
         d = rdata_oe_i ? rdata_i : 8'hxx;
         strb_n_o <= 1'b1;
         tick(4);
         cs_n_o <= 1'b1;
         tick(1);
      end
   endtask
endmodule // lcms_mcu_model

// file: tb/lcms_monitor.sv
`timescale 1ns/1ps
module lcms_monitor (
   // clock and reset
   input wire       clock_i,
   input wire       reset_i,
   // observed pins
   input wire [1:0] control_mode_o,
   input wire       rail_coding_select_hi_i,
   input wire       rail_coding_select_lo_i,
   input wire       ch1_loopback_select_hi_i,
   input wire       ch1_loopback_select_lo_i,
   input wire       recovered_rx_clock_i,
   input wire       rx_rail_positive_o,
   input wire       cs_n_i,
   input wire       data_oe_o,
   input wire       int_o,
   input wire       int_oe_o,
   input wire       dual_rail_o,
   input wire       line_code_ami_o,
   input wire       clock_data_recovery_o,
   input wire       loop_analog_o,
   input wire       loop_digital_o,
   input wire       loop_remote_o,
   input wire       loop_inband_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   wire       hw  = (control_mode_o == 2'b00);
   wire [1:0] cod = {rail_coding_select_hi_i, rail_coding_select_lo_i};
   wire [1:0] lpc = {ch1_loopback_select_hi_i, ch1_loopback_select_lo_i};
   // pins pass two sync flops and a register, so five samples cover the latency
   sequence s_code(logic [1:0] v); (hw && cod == v)[*5]; endsequence
   sequence s_loop(logic [1:0] v); (hw && lpc == v)[*5]; endsequence
   sequence s_cs_idle; cs_n_i[*4]; endsequence
   sequence s_clk_still; $stable(recovered_rx_clock_i)[*6]; endsequence
   a_coding_line: assert property (s_code(2'b00) |-> !dual_rail_o && !line_code_ami_o)
      else $error("coding 00 decoded wrongly");
   a_coding_slicer: assert property (s_code(2'b11) |-> dual_rail_o && !clock_data_recovery_o)
      else $error("slicer coding decoded wrongly");
   a_loop_remote: assert property (s_loop(2'b11) |-> loop_remote_o)
      else $error("remote loopback missing");
   a_loop_analog: assert property (s_loop(2'b01) |-> loop_analog_o)
      else $error("analog loopback missing");
   a_loop_single: assert property ($onehot0({loop_analog_o, loop_digital_o, loop_remote_o}))
      else $error("several loopbacks at once");
   a_inband_hw: assert property (hw && $past(control_mode_o) == 2'b00 |-> !loop_inband_o)
      else $error("in-band loopback in hardware mode");
   a_cs_refused: assert property (s_cs_idle |-> !data_oe_o)
      else $error("bus driven without chip select");
   a_hw_no_bus: assert property (hw && $past(control_mode_o, 3) == 2'b00 |-> !data_oe_o)
      else $error("bus driven in hardware mode");
   a_int_drive: assert property (int_o |-> int_oe_o)
      else $error("interrupt level without drive");
   a_rail_still: assert property (s_clk_still |-> $stable(rx_rail_positive_o))
      else $error("rail moved without clock edge");
endmodule // lcms_monitor

bind lcms_top lcms_monitor mon_u (.*);

// file: tb/lcms_top_test.sv
`timescale 1ns/1ps
module lcms_top_test;
   logic        clock_i = 0, reset_i = 1, recovered_rx_clock_i = 0, par_ds = 0;
   logic [1:0]  mode_select_i = 0, coding = 0, loop = 0, control_mode_o;
   logic        rx_clock_edge_select_i = 0, rail_pos_in_i = 0, rail_neg_in_i = 0;
   logic        cs_n_i, data_or_read_strobe_n_i, dir_or_write_strobe_n_i, data_oe_o;
   logic [5:0]  addr_i;
   logic [7:0]  data_i, data_o, rd_v;
   logic [15:0] irq_event_i = 0;
   logic        rx_rail_positive_o, rx_rail_negative_o, int_o, int_oe_o, dual_rail_o;
   logic        line_code_ami_o, clock_data_recovery_o, loop_analog_o, loop_digital_o;
   logic        loop_remote_o, loop_inband_o;
   wire         rail_coding_select_hi_i = coding[1], rail_coding_select_lo_i = coding[0];
   wire         ch1_loopback_select_hi_i = loop[1], ch1_loopback_select_lo_i = loop[0];
   integer      fail_count = 0, checked = 0;
   always #12.5 clock_i = ~clock_i;
   lcms_top dut_u (.*);
   lcms_mcu_model mcu_u (.clock_i(clock_i), .par_ds_i(par_ds), .rdata_i(data_o),
      .rdata_oe_i(data_oe_o), .cs_n_o(cs_n_i), .addr_o(addr_i),
      .strb_n_o(data_or_read_strobe_n_i), .dir_n_o(dir_or_write_strobe_n_i), .data_o(data_i));
   task chk(input string nm, input [7:0] e, input [7:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clock_i);
   endtask
   task start(input [1:0] m);
      mode_select_i <= m;
      par_ds <= (m == 2'b10);
      reset_i <= 1'b1;
      cyc(10);
      reset_i <= 1'b0;
      cyc(6);
      chk("mode", {6'h0, m}, {6'h0, control_mode_o});
   endtask
   task rchk(input [5:0] a, input [7:0] e);
      mcu_u.rd(a, rd_v);
      chk("register", e, rd_v);
   endtask
   task pin(input string nm, input [1:0] e);
      chk(nm, {6'h0, e}, {6'h0, int_oe_o, int_o});
   endtask
   task t_modes;
      integer m;
      for (m = 0; m < 4; m++) begin
         start(m[1:0]);
         mode_select_i <= ~m[1:0];
         cyc(8);
         chk("strap", {6'h0, m[1:0]}, {6'h0, control_mode_o});
      end
   endtask
   task t_regs(input [1:0] m);
      start(m);
      rchk(6'h13, 8'hff);
      rchk(6'h14, 8'hff);
      rchk(6'h21, 8'h01);
      rchk(6'h3f, 8'h00);
      mcu_u.wr(6'h14, 8'ha5, 1'b1);
      rchk(6'h14, 8'ha5);
      mcu_u.wr(6'h14, 8'h3c, 1'b0);
      rchk(6'h14, 8'ha5);
      mcu_u.wr(6'h19, 8'hff, 1'b1);
      rchk(6'h19, 8'h00);
   endtask
   task t_irq;
      start(2'b11);
      loop <= 2'b11;
      coding <= 2'b11;
      cyc(6);
      chk("pins ignored", 8'h00, {6'h0, loop_remote_o, dual_rail_o});
      mcu_u.wr(6'h01, 8'h2c, 1'b1);
      chk("config", 8'h35, {2'h0, loop_inband_o, loop_analog_o, loop_remote_o,
          dual_rail_o, line_code_ami_o, clock_data_recovery_o});
      loop <= 2'b00;
      coding <= 2'b00;
      irq_event_i <= 16'h0208;
      cyc(1);
      irq_event_i <= 16'h0000;
      cyc(3);
      pin("global mask", 2'b11);
      rchk(6'h18, 8'h08);
      rchk(6'h19, 8'h02);
      mcu_u.wr(6'h13, 8'hf7, 1'b1);
      mcu_u.wr(6'h21, 8'h00, 1'b1);
      pin("active low", 2'b10);
      mcu_u.wr(6'h21, 8'h02, 1'b1);
      pin("active high", 2'b11);
      mcu_u.wr(6'h21, 8'h04, 1'b1);
      pin("open drain", 2'b10);
      // bit 9 still pends but its mask is set, so clearing bit 3 must drop the request
      mcu_u.wr(6'h18, 8'h08, 1'b1);
      pin("cleared", 2'b00);
   endtask
   task t_hw;
      integer c;
      start(2'b00);
      for (c = 0; c < 4; c++) begin
         loop <= c[1:0];
         coding <= c[1:0];
         cyc(6);
         chk("loop", {5'h0, c == 3, c == 2, c == 1},
             {5'h0, loop_remote_o, loop_digital_o, loop_analog_o});
         chk("coding", {5'h0, c[1], c == 1, c != 3},
             {5'h0, dual_rail_o, line_code_ami_o, clock_data_recovery_o});
         chk("inband", 8'h00, {7'h0, loop_inband_o});
      end
      for (c = 0; c < 4; c++) begin
         rx_clock_edge_select_i <= c[1];
         rail_pos_in_i <= (c == 0);
         rail_neg_in_i <= (c != 0);
         cyc(4);
         recovered_rx_clock_i <= ~recovered_rx_clock_i;
         cyc(6);
         chk("rail", {6'h0, c < 3, c == 3},
             {6'h0, rx_rail_positive_o, rx_rail_negative_o});
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      t_modes;
      t_regs(2'b10);
      t_regs(2'b11);
      t_irq;
      t_hw;
      conclude;
   end
   // the sequence needs some 550 clocks; over thirty times that means a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      fail_count++;
      conclude;
   end
endmodule // lcms_top_test
